/* File: asc_defs.svh */
/*
  Register offsets, field positions and idle values of the converter
  control lines. Definitions only; included by the package and the top.
*/
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define ASC_OFS_DAC   8'h00
`define ASC_OFS_MUX   8'h04
`define ASC_OFS_SW    8'h08
`define ASC_OFS_STAT  8'h0C
`define ASC_OFS_IDLE  8'h10

// ==========================================================
// Field positions inside the words
`define ASC_MUX_CHAN_LSB  0
`define ASC_MUX_NEG_LSB   8
`define ASC_STAT_COMP     0
`define ASC_STAT_BUSY     1
`define ASC_STAT_CLASH    2

// ==========================================================
// Idle values of the lines while the converter is unused
`define ASC_IDLE_DAC   10'h200
`define ASC_IDLE_CHAN  8'h01
`define ASC_IDLE_NEG   3'h0
`define ASC_IDLE_SW    14'h2B00

`endif

/* File: asc_pkg.sv */
/*
  Types shared by the converter control block.
  Assumes asc_defs.svh sits in the same folder.
*/
`include "asc_defs.svh"

package asc_pkg;

    // Switch lines, most significant bit first
    typedef struct packed {
        logic gainBypassCh03;
        logic negInputGround;
        logic sampleHold;
        logic bandgapAsDacRef;
        logic gainPassGateOn;
        logic latchPreloadN;
        logic switchcapTestRoute;
        logic quickSettling;
        logic supplyAsReference;
        logic converterPowerOn;
        logic gainPowerOn;
        logic gainClock;
        logic gainX10Select;
        logic gainX20Select;
    } asc_switch_t;

    // All control lines towards the analog section
    typedef struct packed {
        logic [9:0]  dacCode;
        logic [7:0]  inputChannelSelect;
        logic [2:0]  negInputSelect;
        asc_switch_t sw;
    } asc_lines_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } asc_req_t;

endpackage

/* File: asc_scan_ctrl.sv */
/*
  Control lines of the converter analog section, held in registers that
  software loads over a plain register port.
  Assumes: one clock sys_clk at 25 MHz, synchronous active-low reset, the
  comparator output arrives asynchronously from the analog section.
*/
`timescale 1ns/1ns
`include "asc_defs.svh"

module asc_scan_ctrl
    import asc_pkg::*;
(
    input  wire logic        sys_clk,    // 25 MHz clock
    input  wire logic        rst_n,      // Sync reset, low
    input  wire logic        clkEn,      // Freezes all state when low, unless rst_n is low
    input  wire asc_req_t    req,        // Register port request
    output logic      [31:0] rdata,      // Read data, cycle after rd
    input  wire logic        compOut,    // Comparator output, async
    output asc_lines_t       lines       // Control lines to analog
);

    // ==========================================================
    // Decoding
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic        wrEn;        // Write strobe, enabled
    logic        rdEn;        // Read strobe, enabled
    logic        idleCmd;     // Write to the idle address
    logic        compMeta;    // First synchroniser stage
    logic        compSync;    // Comparator, safe to read
    logic        busy;        // Some line away from idle
    logic        clash;       // Two negative sources at once
    logic [31:0] next_rdata;  // Read mux output
    logic [9:0]  dacCode;     // DAC code register
    logic [7:0]  chanSel;     // Input channel selects
    logic [2:0]  negSel;      // Negative input select
    asc_switch_t swLines;     // Switch line register

    assign wrEn    = clkEn && req.wr;
    assign rdEn    = clkEn && req.rd;
    // Idle command wins over a plain write, restoring every line at once
    assign idleCmd = wrEn && hit(req.addr, `ASC_OFS_IDLE);

    // One register per concern, so no two processes share the output
    assign lines = '{dacCode, chanSel, negSel, swLines};

    // ==========================================================
    // DAC code
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || idleCmd)
            dacCode <= `ASC_IDLE_DAC;
        else if (wrEn && hit(req.addr, `ASC_OFS_DAC))
            dacCode <= req.wdata[9:0];
    end

    // ==========================================================
    // Input and negative-input multiplexer selects
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || idleCmd)
        begin
            chanSel <= `ASC_IDLE_CHAN;
            negSel  <= `ASC_IDLE_NEG;
        end
        else if (wrEn && hit(req.addr, `ASC_OFS_MUX))
        begin
            chanSel <= req.wdata[`ASC_MUX_CHAN_LSB +: 8];
            negSel  <= req.wdata[`ASC_MUX_NEG_LSB +: 3];
        end
    end

    // ==========================================================
    // Switch lines; the idle word sets bypass, hold, pass gate and
    // precharge high and every power, reference and test line low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || idleCmd)
            swLines <= `ASC_IDLE_SW;
        else if (wrEn && hit(req.addr, `ASC_OFS_SW))
            swLines <= req.wdata[13:0];
    end

    // ==========================================================
    // Comparator synchroniser; the first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            compMeta <= 1'b0;
            compSync <= 1'b0;
        end
        else if (clkEn)
        begin
            compMeta <= compOut;
            compSync <= compMeta;
        end
    end

    // Status: lines away from idle, and two negative sources at once.
    // The clash flag only reports; the party driving the lines must avoid it.
    assign busy  = (lines != asc_lines_t'({`ASC_IDLE_DAC, `ASC_IDLE_CHAN,
                                          `ASC_IDLE_NEG, `ASC_IDLE_SW}));
    assign clash = lines.sw.negInputGround && (lines.negInputSelect != 3'h0);

    // ==========================================================
    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit(req.addr, `ASC_OFS_DAC))
            next_rdata[9:0] = lines.dacCode;
        else if (hit(req.addr, `ASC_OFS_MUX))
        begin
            next_rdata[`ASC_MUX_CHAN_LSB +: 8] = lines.inputChannelSelect;
            next_rdata[`ASC_MUX_NEG_LSB +: 3]  = lines.negInputSelect;
        end
        else if (hit(req.addr, `ASC_OFS_SW))
            next_rdata[13:0] = lines.sw;
        else if (hit(req.addr, `ASC_OFS_STAT))
        begin
            next_rdata[`ASC_STAT_COMP]  = compSync;
            next_rdata[`ASC_STAT_BUSY]  = busy;
            next_rdata[`ASC_STAT_CLASH] = clash;
        end
    end

    // Read data stands only until the next enabled edge after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rdata <= 32'h0000_0000;
        else if (clkEn)
            rdata <= rdEn ? next_rdata : 32'h0000_0000;
    end

    // ==========================================================
    // Assertions
    property p_dacLowIdle;
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> lines.dacCode[6:0] == 7'h00;
    endproperty
    a_dacLowIdle: assert property (p_dacLowIdle)
        else $error("DAC low bits not idle after reset");

    property p_dacMsbIdle;
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> lines.dacCode[9:7] == 3'h4;
    endproperty
    a_dacMsbIdle: assert property (p_dacMsbIdle)
        else $error("DAC top bits not midscale after reset");

    property p_dacWrite;
        @(posedge sys_clk) disable iff (!rst_n)
        wrEn && hit(req.addr, `ASC_OFS_DAC) |=>
            lines.dacCode == $past(req.wdata[9:0]);
    endproperty
    a_dacWrite: assert property (p_dacWrite)
        else $error("DAC code not taken from write");

    property p_idleHighs;
        @(posedge sys_clk) disable iff (!rst_n)
        idleCmd |=> lines.sw.gainBypassCh03 && lines.sw.sampleHold
            && lines.sw.gainPassGateOn && lines.sw.latchPreloadN;
    endproperty
    a_idleHighs: assert property (p_idleHighs)
        else $error("High-idling line low after idle command");

    property p_idleLows;
        @(posedge sys_clk) disable iff (!rst_n)
        idleCmd |=> !lines.sw.negInputGround && !lines.sw.bandgapAsDacRef
            && !lines.sw.switchcapTestRoute && !lines.sw.supplyAsReference;
    endproperty
    a_idleLows: assert property (p_idleLows)
        else $error("Low-idling line high after idle command");

    property p_powerIdle;
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> !lines.sw.converterPowerOn && !lines.sw.gainPowerOn
            && !lines.sw.gainClock;
    endproperty
    a_powerIdle: assert property (p_powerIdle)
        else $error("Power or gain clock high after reset");

    property p_chanIdle;
        @(posedge sys_clk) disable iff (!rst_n)
        idleCmd ##1 !wrEn |=> lines.inputChannelSelect == 8'h01
            && lines.negInputSelect == 3'h0;
    endproperty
    a_chanIdle: assert property (p_chanIdle)
        else $error("Multiplexer selects not idle");

    property p_freeze;
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n && !clkEn |=> $stable(lines) && $stable(rdata);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State changed while clock enable low");

    property p_statRead;
        @(posedge sys_clk) disable iff (!rst_n)
        rdEn && hit(req.addr, `ASC_OFS_STAT) |=>
            rdata[`ASC_STAT_COMP] == $past(compSync) ##1 !clkEn || rdata == 32'h0 || $past(rdEn);
    endproperty
    a_statRead: assert property (p_statRead)
        else $error("Status read wrong or read data held too long");

    property p_noReadZero;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && !req.rd |=> rdata == 32'h0000_0000;
    endproperty
    a_noReadZero: assert property (p_noReadZero)
        else $error("Read data present without a read");

    property p_muxWrite;
        @(posedge sys_clk) disable iff (!rst_n)
        wrEn && hit(req.addr, `ASC_OFS_MUX) |=>
            lines.inputChannelSelect == $past(req.wdata[`ASC_MUX_CHAN_LSB +: 8])
            && lines.negInputSelect == $past(req.wdata[`ASC_MUX_NEG_LSB +: 3]);
    endproperty
    a_muxWrite: assert property (p_muxWrite)
        else $error("Multiplexer selects not taken from write");

    property p_swWrite;
        @(posedge sys_clk) disable iff (!rst_n)
        wrEn && hit(req.addr, `ASC_OFS_SW) |=> lines.sw == $past(req.wdata[13:0]);
    endproperty
    a_swWrite: assert property (p_swWrite)
        else $error("Switch lines not taken from write");

    // Reset alone must bring the switch lines home, not only the idle write; gainX10Select and gainX20Select go unchecked
    property p_rstHighs;
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> lines.sw.gainBypassCh03 && lines.sw.sampleHold
            && lines.sw.gainPassGateOn && lines.sw.latchPreloadN;
    endproperty
    a_rstHighs: assert property (p_rstHighs)
        else $error("High-idling line low after reset");

    property p_rstLows;
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> !lines.sw.negInputGround && !lines.sw.bandgapAsDacRef
            && !lines.sw.switchcapTestRoute && !lines.sw.supplyAsReference
            && !lines.sw.quickSettling;
    endproperty
    a_rstLows: assert property (p_rstLows)
        else $error("Low-idling line high after reset");

    property p_chanRst;
        @(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> lines.inputChannelSelect == 8'h01
            && lines.negInputSelect == 3'h0;
    endproperty
    a_chanRst: assert property (p_chanRst)
        else $error("Multiplexer selects not idle after reset");

    property p_idleDac;
        @(posedge sys_clk) disable iff (!rst_n)
        idleCmd |=> lines.dacCode == 10'h200;
    endproperty
    a_idleDac: assert property (p_idleDac)
        else $error("DAC code not midscale after idle command");

    property p_idlePower;
        @(posedge sys_clk) disable iff (!rst_n)
        idleCmd |=> !lines.sw.converterPowerOn && !lines.sw.gainPowerOn
            && !lines.sw.gainClock;
    endproperty
    a_idlePower: assert property (p_idlePower)
        else $error("Power or gain clock high after idle command");

    // Two enabled edges from pin to status bit; a skipped stage fails here
    property p_compSync;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn ##1 clkEn |=> compSync == $past(compOut, 2);
    endproperty
    a_compSync: assert property (p_compSync)
        else $error("Comparator not seen two edges after the pin");

    c_idleCmd:  cover property (@(posedge sys_clk) disable iff (!rst_n) idleCmd);
    c_powerUp:  cover property (@(posedge sys_clk) disable iff (!rst_n)
                                $rose(lines.sw.converterPowerOn));
    c_sampleOn: cover property (@(posedge sys_clk) disable iff (!rst_n)
                                $fell(lines.sw.sampleHold) ##[1:20] lines.sw.sampleHold);
    c_clash:    cover property (@(posedge sys_clk) disable iff (!rst_n) clash);

endmodule

/* File: asc_analog_model.sv */
/*
  Behavioural model of the converter analog section driven by the lines.
  Assumes the lines are registered by the block and change after sys_clk.
*/
`timescale 1ns/1ns

module asc_analog_model
    import asc_pkg::*;
#(
    parameter logic [9:0] VIN_CODE = 10'h130  // Analog input as a DAC code
)
(
    input  wire logic       sys_clk,  // Block clock
    input  wire asc_lines_t lines,    // Control lines from the block
    output logic            compOut   // Comparator output
);
    // ==========================================================
    // Sample and hold
    logic [9:0] heldCode = 10'h3FF;  // Full scale until first sample

    // Track the input while low, freeze it while high; a plain process
    // so that the start value above does not count as a second driver
    always @(posedge sys_clk)
    begin
        if (!lines.sw.sampleHold)
        begin
            heldCode <= VIN_CODE;
        end
    end

    // High when powered, precharge released and the DAC code is above the held input
    always_comb
    begin
        compOut = lines.sw.converterPowerOn && lines.sw.latchPreloadN
                  && (lines.dacCode > heldCode);
    end
endmodule

/* File: asc_scan_ctrl_test.sv */
/*
  Self-checking testbench for the converter control lines.
  Assumes the block, its package and the analog model compile first.
*/
`timescale 1ns/1ns
`include "asc_defs.svh"

module asc_scan_ctrl_test
    import asc_pkg::*;
;
    // ==========================================================
    // Signals
    logic        sys_clk;
    logic        rst_n;
    logic        clkEn;
    asc_req_t    req;
    logic [31:0] rdata;
    logic        compOut;
    asc_lines_t  lines;
    int          bad_count = 0;
    int          n_checks = 0;
    localparam asc_lines_t IDLE = {10'h200, 8'h01, 3'h0, 14'h2B00};

    asc_scan_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .req(req),
                         .rdata(rdata), .compOut(compOut), .lines(lines));
    asc_analog_model model_u (.sys_clk(sys_clk), .lines(lines), .compOut(compOut));

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Whole run is about 140 cycles
    initial
    begin
        #(40 * 3000);
        bad_count++;
        test_done();
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        #1;
    endtask

    // Read data stand only until the next enabled edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        chk({3'h0, rdata}, {3'h0, exp});
    endtask

    task automatic test_done();
        $display("Checks %0d, errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        req = '0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk(lines, IDLE);
        rd(`ASC_OFS_STAT, 32'h0);
        @(posedge sys_clk);
        #1;
        chk({3'h0, rdata}, 35'h0);
        // Window check: power on, sample the 10'h130 input, hold, two limits
        wr(`ASC_OFS_SW, 32'h2B10);
        wr(`ASC_OFS_SW, 32'h2310);
        wr(`ASC_OFS_SW, 32'h2B10);
        wr(`ASC_OFS_DAC, 32'h123);
        chk({25'h0, lines.dacCode}, 35'h123);
        repeat (3) @(posedge sys_clk);
        rd(`ASC_OFS_STAT, 32'h2);
        wr(`ASC_OFS_DAC, 32'h143);
        repeat (3) @(posedge sys_clk);
        rd(`ASC_OFS_STAT, 32'h3);
        rd(`ASC_OFS_DAC, 32'h143);
        // Precharge low forces the latch output low
        wr(`ASC_OFS_SW, 32'h2A10);
        repeat (3) @(posedge sys_clk);
        rd(`ASC_OFS_STAT, 32'h2);
        // Walk one switch line at a time through its position
        for (int i = 0; i < 14; i++)
        begin
            wr(`ASC_OFS_SW, 32'h1 << i);
            chk({21'h0, lines.sw}, 35'h1 << i);
            rd(`ASC_OFS_SW, 32'h1 << i);
        end
        // Channel and negative input select, single negative source
        wr(`ASC_OFS_SW, 32'h2B00);
        wr(`ASC_OFS_MUX, {21'h0, 3'h5, 8'h80});
        chk({24'h0, lines.inputChannelSelect, lines.negInputSelect}, 35'h405);
        rd(`ASC_OFS_MUX, 32'h580);
        // Ground plus a selected pin is reported as a clash
        wr(`ASC_OFS_SW, 32'h3B00);
        rd(`ASC_OFS_STAT, 32'h6);
        // Unmapped place reads zero and ignores writes
        wr(8'h14, 32'hFFFFFFFF);
        chk(lines, {10'h143, 8'h80, 3'h5, 14'h3B00});
        rd(8'h14, 32'h0);
        // Write strobe ignored while the clock enable is low
        @(posedge sys_clk);
        clkEn <= 1'b0;
        wr(`ASC_OFS_DAC, 32'h3FF);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        #1;
        chk({25'h0, lines.dacCode}, 35'h143);
        // Gain stages: settle assist for two gain clocks, hold rises with clock high
        wr(`ASC_OFS_SW, 32'h0B58);
        wr(`ASC_OFS_SW, 32'h0B5C);
        wr(`ASC_OFS_SW, 32'h0B58);
        wr(`ASC_OFS_SW, 32'h0B5C);
        wr(`ASC_OFS_SW, 32'h0B58);
        wr(`ASC_OFS_SW, 32'h0B1C);
        wr(`ASC_OFS_SW, 32'h031C);
        wr(`ASC_OFS_SW, 32'h0B1C);
        rd(`ASC_OFS_SW, 32'h0B1C);
        rd(`ASC_OFS_STAT, 32'h3);
        // Idle write restores every line
        wr(`ASC_OFS_IDLE, 32'h0);
        chk(lines, IDLE);
        // Reset in mid-run wins over a low clock enable
        wr(`ASC_OFS_DAC, 32'h3FF);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        clkEn <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        clkEn <= 1'b1;
        #1;
        chk(lines, IDLE);
        chk({3'h0, rdata}, 35'h0);
        rd(`ASC_OFS_STAT, 32'h0);
        test_done();
    end
endmodule
